// [slem_monitor.sv]
`timescale 1ns/1ns
`include "slem_defs.svh"
// How it works
// R01: Transmission fault logs code 84h
// R02: Exception 01h/02h logs code 88h
// R03: Exception 04h logs 89h or 8Ah
// R04: Range exception 03h/04h logs 8Ch
// R05: Non-executable command logs code 8Dh
// R06: Record volatile, readable, empty after reset
// R07: Alarm drops fault output, stops, blinks
// R08: Warning raises caution output, self-clearing
// R09: Rate switch 8 to F logs 83h
// R10: One transmission error raises warning
// R11: Valid frame clears active warning
// R12: Consecutive errors reaching count raise alarm
// R13: No valid traffic until timeout alarms
// R14: Response waits wait+C3.5+processing time
// R15: Outputs update within C3.5 plus 4 ms
// R16: Reconfiguration done within processing plus 1 s
// R17: Master waits for configuration to finish
// R18: Stop action parameter picks deceleration
// R19: Good frame clears consecutive error counter
module slem_monitor #(
  parameter int unsigned OUT_MAX_CYC = `SLEM_OUT_CYC,
  parameter int unsigned CFG_MAX_CYC = `SLEM_CFG_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_ok,
  input wire logic frame_err,
  input wire logic exc_valid,
  input wire slem_pkg::slem_exc_cause_t exc_cause,
  input wire logic query_end,
  input wire slem_pkg::slem_qkind_t query_kind,
  input wire logic rate_switch_bit3,
  output logic resp_start,
  output logic out_update,
  output logic cfg_busy,
  output logic stop_slow,
  output logic fault_output,
  output logic caution_output,
  output logic motor_stop,
  output logic alarm_lamp,
  output logic irq
);
  import slem_pkg::*;
  logic [31:0] tmo_q, transmit_wait_time_q, proc_q, c35_q, idle_cnt_q, rs_cnt_q, out_cnt_q, cfg_cnt_q;
  logic [7:0] err_limit_q, err_run_q, log_code;
  logic [4:0] irq_stat_q, irq_mask_q, log_cnt_q, irq_ev;
  logic stop_mode_q, sw_s1_q, sw_s2_q, switch_err_q, warn_q, alarm_q, tmo_alarm_q;
  logic log_we, alarm_set, wr_en, rd_en;
  logic [7:0] log_mem [`SLEM_LOG_DEPTH];
  logic [3:0] log_wr_q;
  logic [22:0] blink_q;
  slem_resp_state_t rs_q;
  // Single-cycle APB answer: nothing behind it stalls
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  // Rate switch comes from a pin, two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_s1_q <= 1'b0;
      sw_s2_q <= 1'b0;
      switch_err_q <= 1'b0;
    end
    else
    begin
      sw_s1_q <= rate_switch_bit3;
      sw_s2_q <= sw_s1_q;
      // R09: switch position check
      switch_err_q <= sw_s2_q; // Positions 8..F all have bit 3 set
    end
  end
  // Pick one code per cycle; errors are exclusive per frame
  always_comb
  begin
    log_we = 1'b0;
    log_code = 8'h00;
    if (sw_s2_q && !switch_err_q)
    begin
      log_we = 1'b1;
      log_code = `SLEM_CODE_SWITCH;
    end
    // R01: transmission fault code
    else if (frame_err)
    begin
      log_we = 1'b1;
      log_code = `SLEM_CODE_XMIT;
    end
    else if (exc_valid)
    begin
      log_we = (exc_cause != SLEM_EXC_NONE);
      unique case (exc_cause)
        // R02: undefined command
        SLEM_EXC_UNDEF: log_code = `SLEM_CODE_UNDEF;
        // R03: busy exceptions split
        SLEM_EXC_UIF_BUSY: log_code = `SLEM_CODE_UIF_BUSY;
        SLEM_EXC_NVM_BUSY: log_code = `SLEM_CODE_NVM_BUSY;
        // R04: value out of range
        SLEM_EXC_RANGE: log_code = `SLEM_CODE_RANGE;
        // R05: command not executable
        SLEM_EXC_NOEXEC: log_code = `SLEM_CODE_NOEXEC;
        default: log_code = 8'h00;
      endcase
    end
    // R13: timeout code once on entry
    else if (idle_cnt_q >= tmo_q && tmo_q != 32'h0 && !tmo_alarm_q)
    begin
      log_we = 1'b1;
      log_code = `SLEM_CODE_TIMEOUT;
    end
  end

  // R06: record in plain RAM, never cleared; reset zeroes only the write pointer and count
  always_ff @(posedge pclk)
  begin
    if (log_we)
      log_mem[log_wr_q] <= log_code;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      log_wr_q <= 4'h0;
      log_cnt_q <= 5'h00;
    end
    else if (log_we)
    begin
      log_wr_q <= log_wr_q + 4'h1;
      if (log_cnt_q != 5'(`SLEM_LOG_DEPTH))
        log_cnt_q <= log_cnt_q + 5'h01;
    end
  end

  // R19: run counter of consecutive faults
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      err_run_q <= 8'h00;
    else if (frame_ok)
      err_run_q <= 8'h00;
    else if (frame_err && err_run_q != 8'hff)
      err_run_q <= err_run_q + 8'h01;
  end

  // R12: threshold reached on this error
  assign alarm_set = frame_err && (err_run_q + 8'h01 >= err_limit_q) && err_limit_q != 8'h00;

  // R10: warning on a single fault
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      warn_q <= 1'b0;
    else if (frame_err)
      warn_q <= 1'b1;
    // R11: good frame clears warning
    else if (frame_ok)
      warn_q <= 1'b0;
  end

  // Alarms latch until reset; no alarm-reset path in this block
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alarm_q <= 1'b0;
    else if (alarm_set || switch_err_q)
      alarm_q <= 1'b1;
  end

  // R13: silence counter, restarted by valid traffic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idle_cnt_q <= 32'h0;
      tmo_alarm_q <= 1'b0;
    end
    else
    begin
      if (frame_ok || tmo_q == 32'h0)
        idle_cnt_q <= 32'h0;
      else if (idle_cnt_q < tmo_q)
        idle_cnt_q <= idle_cnt_q + 32'h1;
      if (tmo_q != 32'h0 && idle_cnt_q >= tmo_q) // A shortened limit still trips
        tmo_alarm_q <= 1'b1;
    end
  end

  // R07: blink divider for the lamp
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      blink_q <= 23'h0;
    else if (alarm_q || tmo_alarm_q)
      blink_q <= blink_q + 23'h1;
    else
      blink_q <= 23'h0;
  end

  // R07: fault output active-off; R08: caution follows warning
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_output <= 1'b1;
      motor_stop <= 1'b0;
      alarm_lamp <= 1'b0;
      caution_output <= 1'b0;
    end
    else
    begin
      fault_output <= ~(alarm_q | tmo_alarm_q);
      motor_stop <= alarm_q | tmo_alarm_q;
      alarm_lamp <= (alarm_q | tmo_alarm_q) & blink_q[22];
      caution_output <= warn_q;
    end
  end

  // R14: response delay sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rs_q <= SLEM_RS_IDLE;
      rs_cnt_q <= 32'h0;
      resp_start <= 1'b0;
    end
    else
    begin
      resp_start <= 1'b0;
      unique case (rs_q)
        SLEM_RS_IDLE:
        if (query_end)
        begin
          rs_q <= SLEM_RS_WAIT;
          rs_cnt_q <= transmit_wait_time_q + c35_q + proc_q;
        end
        SLEM_RS_WAIT:
        if (rs_cnt_q == 32'h0)
          rs_q <= SLEM_RS_GO;
        else
          rs_cnt_q <= rs_cnt_q - 32'h1;
        SLEM_RS_GO:
        begin
          resp_start <= 1'b1;
          rs_q <= SLEM_RS_IDLE;
        end
      endcase
    end
  end

  // R15: output update after C3.5 plus bounded margin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_cnt_q <= 32'h0;
      out_update <= 1'b0;
    end
    else
    begin
      out_update <= 1'b0;
      if (query_end && query_kind == SLEM_Q_OUTPUT)
        out_cnt_q <= (c35_q < OUT_MAX_CYC) ? c35_q + 32'h1 : OUT_MAX_CYC; // Cap keeps a huge C3.5 in bound
      else if (out_cnt_q == 32'h1)
      begin
        out_cnt_q <= 32'h0;
        out_update <= 1'b1; // Never later than OUT_MAX_CYC
      end
      else if (out_cnt_q != 32'h0)
        out_cnt_q <= out_cnt_q - 32'h1;
    end
  end

  // R16: configuration busy window, processing plus one cycle, capped at CFG_MAX_CYC
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_cnt_q <= 32'h0;
      cfg_busy <= 1'b0;
    end
    else if (query_end && query_kind == SLEM_Q_CONFIG)
    begin
      cfg_cnt_q <= (proc_q < CFG_MAX_CYC) ? proc_q + 32'h1 : CFG_MAX_CYC;
      cfg_busy <= 1'b1;
    end
    // R17: busy tells master to hold off
    else if (cfg_cnt_q != 32'h0)
    begin
      cfg_cnt_q <= cfg_cnt_q - 32'h1;
      cfg_busy <= (cfg_cnt_q != 32'h1);
    end
  end

  // R18: stop action chosen from the parameter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stop_slow <= 1'b0;
    else if (query_end && query_kind == SLEM_Q_STOP)
      stop_slow <= stop_mode_q;
  end

  // Interrupt events: log write, warning, alarm, timeout, switch
  assign irq_ev = {sw_s2_q & ~switch_err_q, log_we && log_code == `SLEM_CODE_TIMEOUT, alarm_set, frame_err, log_we};

  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stop_mode_q <= 1'b0;
      err_limit_q <= `SLEM_ERRCNT_RST;
      tmo_q <= `SLEM_TMO_RST;
      transmit_wait_time_q <= `SLEM_WAIT_RST;
      proc_q <= `SLEM_PROC_RST;
      c35_q <= `SLEM_C35_RST;
      irq_mask_q <= 5'h00;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `SLEM_CTRL_OFF: stop_mode_q <= pwdata[0];
        `SLEM_IRQ_MASK_OFF: irq_mask_q <= pwdata[4:0];
        `SLEM_ERRCNT_OFF: err_limit_q <= pwdata[7:0];
        `SLEM_TMO_OFF: tmo_q <= pwdata;
        `SLEM_WAIT_OFF: transmit_wait_time_q <= pwdata;
        `SLEM_PROC_OFF: proc_q <= pwdata;
        `SLEM_C35_OFF: c35_q <= pwdata;
        default: ;
      endcase
    end
  end

  // Sticky status, write one to clear; a new event wins the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_q <= 5'h00;
    else if (wr_en && paddr == `SLEM_IRQ_STAT_OFF)
      irq_stat_q <= (irq_stat_q & ~pwdata[4:0]) | irq_ev;
    else
      irq_stat_q <= irq_stat_q | irq_ev;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read mux; unmapped reads return zero with an error
  always_comb
  begin
    prdata = 32'h0;
    pslverr = 1'b0;
    if (rd_en || wr_en)
    begin
      if (paddr >= `SLEM_LOG_BASE_OFF && paddr < `SLEM_LOG_BASE_OFF + 12'(4 * `SLEM_LOG_DEPTH))
      begin
        if (rd_en)
          prdata = {24'h0, log_mem[paddr[5:2]]};
        else
          pslverr = 1'b1;
      end
      else
      begin
        unique case (paddr)
          `SLEM_CTRL_OFF: prdata = {31'h0, stop_mode_q};
          `SLEM_STAT_OFF: prdata = {26'h0, cfg_busy, switch_err_q, tmo_alarm_q, alarm_q, warn_q, ~fault_output};
          `SLEM_IRQ_STAT_OFF: prdata = {27'h0, irq_stat_q};
          `SLEM_IRQ_MASK_OFF: prdata = {27'h0, irq_mask_q};
          `SLEM_ERRCNT_OFF: prdata = {16'h0, err_run_q, err_limit_q};
          `SLEM_TMO_OFF: prdata = tmo_q;
          `SLEM_WAIT_OFF: prdata = transmit_wait_time_q;
          `SLEM_PROC_OFF: prdata = proc_q;
          `SLEM_C35_OFF: prdata = c35_q;
          `SLEM_LOG_CNT_OFF: prdata = {23'h0, log_wr_q, log_cnt_q};
          default: pslverr = 1'b1;
        endcase
        if (!rd_en)
          prdata = 32'h0;
        if (wr_en && (paddr == `SLEM_STAT_OFF || paddr == `SLEM_LOG_CNT_OFF))
          pslverr = 1'b1;
      end
    end
  end

endmodule // slem_monitor

// [slem_defs.svh]
`ifndef SLEM_DEFS_SVH
`define SLEM_DEFS_SVH
// Register byte offsets
`define SLEM_CTRL_OFF 12'h000
`define SLEM_STAT_OFF 12'h004
`define SLEM_IRQ_STAT_OFF 12'h008
`define SLEM_IRQ_MASK_OFF 12'h00c
`define SLEM_ERRCNT_OFF 12'h010
`define SLEM_TMO_OFF 12'h014
`define SLEM_WAIT_OFF 12'h018
`define SLEM_PROC_OFF 12'h01c
`define SLEM_C35_OFF 12'h020
`define SLEM_LOG_CNT_OFF 12'h024
`define SLEM_LOG_BASE_OFF 12'h040
// Error codes
`define SLEM_CODE_SWITCH 8'h83
`define SLEM_CODE_XMIT 8'h84
`define SLEM_CODE_TIMEOUT 8'h85
`define SLEM_CODE_UNDEF 8'h88
`define SLEM_CODE_UIF_BUSY 8'h89
`define SLEM_CODE_NVM_BUSY 8'h8a
`define SLEM_CODE_RANGE 8'h8c
`define SLEM_CODE_NOEXEC 8'h8d
// Exception codes
`define SLEM_EXC_01 8'h01
`define SLEM_EXC_02 8'h02
`define SLEM_EXC_03 8'h03
`define SLEM_EXC_04 8'h04
// Reset values
`define SLEM_ERRCNT_RST 8'h03
`define SLEM_TMO_RST 32'h0000_0000
`define SLEM_WAIT_RST 32'h0000_0000
`define SLEM_PROC_RST 32'h0000_0000
`define SLEM_C35_RST 32'h0000_0000
// Timing
`define SLEM_CLK_MHZ 125
`define SLEM_OUT_MAX_MS 4
`define SLEM_CFG_MAX_MS 1000
`define SLEM_OUT_CYC (`SLEM_OUT_MAX_MS * `SLEM_CLK_MHZ * 1000)
`define SLEM_CFG_CYC (`SLEM_CFG_MAX_MS * `SLEM_CLK_MHZ * 1000)
// Record depth and interrupt bits
`define SLEM_LOG_DEPTH 16
`define SLEM_IRQ_LOG 0
`define SLEM_IRQ_WARN 1
`define SLEM_IRQ_ALARM 2
`define SLEM_IRQ_TMO 3
`define SLEM_IRQ_SWITCH 4
`endif

// [slem_pkg.sv]
package slem_pkg;
  typedef enum logic [2:0] {
    SLEM_EXC_NONE,
    SLEM_EXC_UNDEF,
    SLEM_EXC_UIF_BUSY,
    SLEM_EXC_NVM_BUSY,
    SLEM_EXC_RANGE,
    SLEM_EXC_NOEXEC
  } slem_exc_cause_t;
  typedef enum logic [1:0] {
    SLEM_Q_PLAIN,
    SLEM_Q_OUTPUT,
    SLEM_Q_CONFIG,
    SLEM_Q_STOP
  } slem_qkind_t;
  typedef enum logic [1:0] {
    SLEM_RS_IDLE,
    SLEM_RS_WAIT,
    SLEM_RS_GO
  } slem_resp_state_t;
endpackage

// [slem_chk_monitor.sv]
`timescale 1ns/1ns
module slem_chk
  import slem_pkg::*;
#(
  parameter int unsigned CFG_MAX_CYC = 200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_ok,
  input wire logic frame_err,
  input wire logic query_end,
  input wire slem_pkg::slem_qkind_t query_kind,
  input wire logic cfg_busy,
  input wire logic fault_output,
  input wire logic caution_output,
  input wire logic motor_stop,
  input wire logic alarm_lamp
);
  logic [31:0] busy_q;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Busy stretch length; a restart would hide an overrun
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      busy_q <= '0;
    else
      busy_q <= cfg_busy ? busy_q + 32'h1 : '0;
  sequence s_bad;
    frame_err && !frame_ok;
  endsequence
  sequence s_good;
    frame_ok && !frame_err;
  endsequence
  chk_alarm_pins: assert property (fault_output != motor_stop)
    else $error("fault and stop disagree");
  chk_alarm_held: assert property (motor_stop |=> motor_stop)
    else $error("alarm dropped");
  chk_lamp_idle: assert property (!motor_stop |-> !alarm_lamp)
    else $error("lamp without alarm");
  chk_err_warn: assert property (s_bad |-> ##[1:2] caution_output)
    else $error("no warning after fault");
  chk_good_clear: assert property (s_good |-> ##[1:3] !caution_output)
    else $error("warning kept after good frame");
  chk_warn_cause: assert property ($fell(caution_output) |-> $past(frame_ok) || $past(frame_ok, 2))
    else $error("warning cleared without cause");
  chk_cfg_start: assert property (query_end && query_kind == SLEM_Q_CONFIG |=> cfg_busy)
    else $error("no reconfiguration");
  chk_cfg_bound: assert property (busy_q <= CFG_MAX_CYC)
    else $error("reconfiguration too long");
endmodule // slem_chk
bind slem_monitor slem_chk #(.CFG_MAX_CYC(CFG_MAX_CYC)) u_chk (.*);

// [slem_mst_model.sv]
`timescale 1ns/1ns
module slem_mst
  import slem_pkg::*;
(
  input wire logic pclk,
  input wire logic cfg_busy,
  output logic frame_ok,
  output logic frame_err,
  output logic exc_valid,
  output slem_pkg::slem_exc_cause_t exc_cause,
  output logic query_end,
  output slem_pkg::slem_qkind_t query_kind
);
  // Quiet link at start
  initial
  begin
    frame_ok = 1'b0;
    frame_err = 1'b0;
    exc_valid = 1'b0;
    exc_cause = SLEM_EXC_NONE;
    query_end = 1'b0;
    query_kind = SLEM_Q_PLAIN;
  end
  // One received frame, good or broken
  task automatic frame(input logic good);
    frame_ok <= good;
    frame_err <= !good;
    @(posedge pclk);
    frame_ok <= 1'b0;
    frame_err <= 1'b0;
  endtask
  // Qualifiers are scrambled once released
  task automatic exc(input slem_exc_cause_t c);
    exc_cause <= c;
    exc_valid <= 1'b1;
    @(posedge pclk);
    exc_valid <= 1'b0;
    exc_cause <= slem_exc_cause_t'(~c);
  endtask
  task automatic query(input slem_qkind_t k, output int n);
    n = 0;
    // wait out reconfiguration, judged one edge later so busy has settled
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (cfg_busy === 1'b1 && n < 2000);
    query_kind <= k;
    query_end <= 1'b1;
    @(posedge pclk);
    query_end <= 1'b0;
    query_kind <= slem_qkind_t'(~k);
  endtask
endmodule // slem_mst

// [testbench.sv]
`timescale 1ns/1ns
`include "slem_defs.svh"
module testbench;
  import slem_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e, a;
  logic frame_ok, frame_err, exc_valid, query_end, rate_switch_bit3;
  logic resp_start, out_update, cfg_busy, stop_slow, fault_output, caution_output, motor_stop, alarm_lamp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  slem_exc_cause_t exc_cause;
  slem_qkind_t query_kind;
  slem_exc_cause_t cz[5] = '{SLEM_EXC_UNDEF, SLEM_EXC_UIF_BUSY, SLEM_EXC_NVM_BUSY, SLEM_EXC_RANGE, SLEM_EXC_NOEXEC};
  logic [7:0] cd[5] = '{8'h88, 8'h89, 8'h8a, 8'h8c, 8'h8d};
  int err_total = 0;
  int tests_run = 0;
  int idx, r, o, b, w;
  slem_monitor #(.CFG_MAX_CYC(200)) dut (.*);
  slem_mst u_mst (.*);
  // 125 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, x, s);
    end
  endtask
  // APB transfer, then one idle cycle so strobes never toggle twice
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_total++;
      end_sim;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input string nm, input logic [11:0] ad, input logic [31:0] x, input logic [31:0] m);
    apb(1'b0, ad, 32'h0);
    chk(nm, q & m, x);
  endtask
  // Next record entry must hold this code
  task automatic lg(input string nm, input logic [7:0] c);
    rd(nm, 12'(`SLEM_LOG_BASE_OFF + 4 * idx), {24'h0, c}, 32'hff);
    idx++;
  endtask
  task automatic rst;
    presetn <= 1'b0;
    rate_switch_bit3 <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    idx = 0;
    @(posedge pclk);
  endtask
  task automatic fl(input int lim);
    int n = 0;
    while (fault_output !== 1'b0 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    if (fault_output !== 1'b0)
    begin
      err_total++;
      end_sim;
    end
  endtask
  // Query through the partner; a reconfiguration that never ends fails the run
  task automatic qry(input slem_qkind_t k);
    u_mst.query(k, w);
    if (w >= 2000)
    begin
      err_total++;
      end_sim;
    end
  endtask
  // Delays counted in cycles after the query is taken
  task automatic meas(input slem_qkind_t k);
    r = -1;
    o = -1;
    b = 0;
    qry(k);
    for (int m = 0; m < 60; m++)
    begin
      @(negedge pclk);
      if (resp_start === 1'b1 && r < 0)
        r = m;
      if (out_update === 1'b1 && o < 0)
        o = m;
      if (cfg_busy === 1'b1)
        b++;
    end
    @(posedge pclk);
  endtask
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rst;
    // Reset contents and refused accesses
    rd("errcnt", `SLEM_ERRCNT_OFF, 32'h3, 32'hffff);
    rd("logcnt", `SLEM_LOG_CNT_OFF, 32'h0, 32'h1f);
    apb(1'b1, `SLEM_STAT_OFF, 32'h1);
    chk("ro_err", {31'h0, e}, 32'h1);
    apb(1'b0, 12'hffc, 32'h0);
    chk("map_err", {31'h0, e}, 32'h1);
    $display("regs done");
    // Exception codes, then interrupt mask and clear
    apb(1'b1, `SLEM_IRQ_MASK_OFF, 32'h0);
    foreach (cz[i])
    begin
      u_mst.exc(cz[i]);
      lg("exc_code", cd[i]);
    end
    a = irq;
    apb(1'b1, `SLEM_IRQ_MASK_OFF, 32'h1f);
    rd("irq_stat", `SLEM_IRQ_STAT_OFF, 32'h1, 32'h1f);
    chk("irq_mask", {31'h0, a ^ irq}, 32'h1);
    apb(1'b1, `SLEM_IRQ_STAT_OFF, 32'h1f);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    // Fault warns, good frame clears; only an unbroken run alarms
    u_mst.frame(1'b0);
    lg("xmit_code", 8'h84);
    rd("run_one", `SLEM_ERRCNT_OFF, 32'h100, 32'hff00);
    chk("warn_on", {31'h0, caution_output}, 32'h1);
    u_mst.frame(1'b1);
    repeat (2) @(posedge pclk);
    chk("warn_off", {31'h0, caution_output}, 32'h0);
    rd("run_clr", `SLEM_ERRCNT_OFF, 32'h0, 32'hff00);
    for (int i = 0; i < 6; i++)
    begin
      u_mst.frame(i == 2);
      @(posedge pclk);
      if (i == 4)
        chk("no_alarm", {31'h0, fault_output}, 32'h1);
    end
    repeat (2) @(posedge pclk);
    chk("alarm_pin", {31'h0, fault_output}, 32'h0);
    chk("alarm_stop", {31'h0, motor_stop}, 32'h1);
    $display("frames done");
    // Response, update and reconfiguration timing; stop mode
    rst;
    apb(1'b1, `SLEM_WAIT_OFF, 32'h5);
    apb(1'b1, `SLEM_C35_OFF, 32'h7);
    apb(1'b1, `SLEM_PROC_OFF, 32'h3);
    meas(SLEM_Q_OUTPUT);
    chk("resp_dly", 32'(r), 32'h11);
    chk("upd_dly", 32'(o), 32'h8);
    meas(SLEM_Q_CONFIG);
    chk("cfg_len", 32'(b), 32'h4);
    // Long processing hits the 200-cycle cap; the next query is held off
    apb(1'b1, `SLEM_PROC_OFF, 32'h1000);
    qry(SLEM_Q_CONFIG);
    qry(SLEM_Q_PLAIN);
    chk("cfg_cap", 32'(w), 32'hc9);
    for (int v = 0; v < 2; v++)
    begin
      apb(1'b1, `SLEM_CTRL_OFF, 32'(v));
      qry(SLEM_Q_STOP);
      repeat (2) @(posedge pclk);
      chk("stop_mode", {31'h0, stop_slow}, 32'(v));
    end
    $display("timing done");
    // Silent link, then a bad rate switch
    rst;
    apb(1'b1, `SLEM_TMO_OFF, 32'h32);
    fl(100);
    lg("tmo_code", 8'h85);
    rst;
    rate_switch_bit3 <= 1'b1;
    fl(20);
    lg("sw_code", 8'h83);
    $display("alarms done");
    end_sim;
  end
endmodule // testbench
